// >>> bench/fbc_mem_model.sv
// Data memory model standing behind the core's memory port.
// Assumes the core drives pointer parts and write strobe on pclk.
`timescale 1ns/1ps
module fbc_mem_model (
  input wire logic pclk,
  input wire logic [11:0] instr_addr,
  input wire logic [2:0] pointer_high_part,
  input wire logic [2:0] pointer_middle_part,
  input wire logic [3:0] pointer_low_part,
  input wire logic mem_we,
  input wire logic [9:0] mem_addr,
  input wire logic [3:0] mem_wdata,
  output logic [3:0] mem_rdata
);
  // ****************************************
  // Storage and ports
  // ****************************************
  logic [3:0] mem [1024];
  wire logic use_pointer = (instr_addr == 12'h00f);
  wire logic [9:0] rd_addr;

  // Index location reads through the pointer, others direct
  assign rd_addr = use_pointer ? {pointer_high_part, pointer_middle_part,
                                  pointer_low_part} : instr_addr[9:0];
  assign mem_rdata = mem[rd_addr];

  // Zero fill so that no read returns an unknown
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 4'h0;
    end
  end

  // Static cells keep contents whatever mode the core is in
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the four-bit core: APB and instruction tasks.
// Assumes the memory model beside it and one 200 MHz clock.
`timescale 1ns/1ps
module testbench import fbc_pkg::*;;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic instr_valid, irq_timer, irq_port, low_power_mode, carry_flag;
  logic [4:0] instr_op;
  logic [11:0] instr_addr, fetch_addr;
  logic [7:0] instr_imm;
  logic [3:0] mem_rdata, accum_reg, table_branch_reg, pointer_low_part, mem_wdata;
  logic [2:0] pointer_high_part, pointer_middle_part;
  logic mem_we, irq_ack, er, seen;
  logic [9:0] mem_addr;
  int n_mismatch, n_compared;

  fbc_core i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_addr(instr_addr), .instr_imm(instr_imm),
    .mem_rdata(mem_rdata), .irq_timer(irq_timer), .irq_port(irq_port),
    .low_power_mode(low_power_mode), .fetch_addr(fetch_addr), .accum_reg(accum_reg),
    .carry_flag(carry_flag), .table_branch_reg(table_branch_reg),
    .pointer_high_part(pointer_high_part), .pointer_middle_part(pointer_middle_part),
    .pointer_low_part(pointer_low_part), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .irq_ack(irq_ack));

  fbc_mem_model i_mem (.pclk(pclk), .instr_addr(instr_addr),
    .pointer_high_part(pointer_high_part), .pointer_middle_part(pointer_middle_part),
    .pointer_low_part(pointer_low_part), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // Clock generator
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; the wait for pready is bounded
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_mismatch++;
      $display("CHECK FAILED pready expected 1 seen 0");
      wrap_up();
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eer);
    apb(1'b0, a, 32'h0);
    chk("prdata", exp, rd);
    chk("pslverr", 32'(eer), 32'(er));
  endtask

  // Issue one instruction; ecy bit 1 set means carry not compared
  task automatic step(input fbc_op_t op, input logic [11:0] a, input logic [7:0] imm,
                      input logic [11:0] epc, input logic [3:0] eacc, input logic [1:0] ecy);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_addr <= a;
    instr_imm <= imm;
    @(posedge pclk);
    instr_valid <= 1'b0;
    #1;
    chk("pc", 32'(epc), 32'(fetch_addr));
    chk("acc", 32'(eacc), 32'(accum_reg));
    if (!ecy[1]) begin
      chk("carry", 32'(ecy[0]), 32'(carry_flag));
    end
  endtask

  task automatic irq(input logic t, input logic p, input logic [11:0] epc);
    @(posedge pclk);
    irq_timer <= t;
    irq_port <= p;
    @(posedge pclk);
    irq_timer <= 1'b0;
    irq_port <= 1'b0;
    #1;
    chk("pc", 32'(epc), 32'(fetch_addr));
    seen = irq_ack;
    @(posedge pclk);
    #1;
    chk("irq_ack", 32'h1, 32'(seen | irq_ack));
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, instr_valid, irq_timer, irq_port} = '0;
    {low_power_mode, paddr, pwdata, instr_op, instr_addr, instr_imm} = '0;
    clk_en = 1'b1;
    n_mismatch = 0;
    n_compared = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state, register map, widths and refusals
    rdc(8'h80, 32'h0, 1'b0);
    rdc(8'h84, 32'h1, 1'b0);
    apb(1'b1, 8'h38, 32'hff);
    rdc(8'h38, 32'hf, 1'b0);
    apb(1'b1, 8'h40, 32'h15);
    apb(1'b1, 8'h44, 32'hfa);
    apb(1'b1, 8'h48, 32'hff);
    rdc(8'h40, 32'h5, 1'b0);
    rdc(8'h44, 32'h2, 1'b0);
    rdc(8'h48, 32'h7, 1'b0);
    apb(1'b1, 8'h3c, 32'h9);
    rdc(8'h3c, 32'h0, 1'b0);
    rdc(8'h4c, 32'h0, 1'b1);
    rdc(8'h3a, 32'h0, 1'b1);
    apb(1'b1, 8'h38, 32'ha);
    i_mem.mem[10'h030] = 4'h6;
    // Jumps, arithmetic, decimal adjust, logic, branches
    step(OP_JMP, 12'h800, 8'h0, 12'h800, 4'h0, 2'b00);
    step(OP_NOP, 12'h0, 8'h0, 12'h801, 4'h0, 2'b00);
    step(OP_ADI, 12'h0, 8'h9, 12'h802, 4'h9, 2'b00);
    step(OP_ADI, 12'h0, 8'h9, 12'h803, 4'h2, 2'b01);
    step(OP_DAA, 12'h0, 8'h0, 12'h804, 4'h8, 2'b01);
    step(OP_SBI, 12'h0, 8'h9, 12'h805, 4'hf, 2'b00);
    step(OP_DAS, 12'h0, 8'h0, 12'h806, 4'h9, 2'b10);
    step(OP_SHR, 12'h0, 8'h0, 12'h807, 4'h4, 2'b01);
    step(OP_AND, 12'h030, 8'h0, 12'h808, 4'h4, 2'b10);
    step(OP_OR, 12'h030, 8'h0, 12'h809, 4'h6, 2'b10);
    step(OP_EOR, 12'h030, 8'h0, 12'h80a, 4'h0, 2'b10);
    step(OP_ADD, 12'h030, 8'h0, 12'h80b, 4'h6, 2'b00);
    step(OP_ADC, 12'h030, 8'h0, 12'h80c, 4'hc, 2'b00);
    step(OP_ADC, 12'h030, 8'h0, 12'h80d, 4'h2, 2'b01);
    step(OP_ADC, 12'h030, 8'h0, 12'h80e, 4'h9, 2'b00);
    step(OP_SUB, 12'h030, 8'h0, 12'h80f, 4'h3, 2'b01);
    step(OP_SBC, 12'h030, 8'h0, 12'h810, 4'hd, 2'b00);
    step(OP_SBC, 12'h030, 8'h0, 12'h811, 4'h6, 2'b01);
    step(OP_BC, 12'h050, 8'h0, 12'h850, 4'h6, 2'b01);
    step(OP_BNC, 12'h060, 8'h0, 12'h851, 4'h6, 2'b01);
    step(OP_BNZ, 12'h070, 8'h0, 12'h870, 4'h6, 2'b01);
    step(OP_BAZ, 12'h080, 8'h0, 12'h871, 4'h6, 2'b01);
    step(OP_BA, 12'h090, 8'h1, 12'h890, 4'h6, 2'b01);
    step(OP_BA, 12'h0a0, 8'h0, 12'h891, 4'h6, 2'b01);
    // Indirect store and load through the pointer, memory-immediate forms
    step(OP_STA, 12'h00f, 8'h0, 12'h892, 4'h6, 2'b10);
    chk("mem_we", 32'h1, 32'(mem_we));
    chk("mem_addr", 32'h3a5, 32'(mem_addr));
    chk("mem_wdata", 32'h6, 32'(mem_wdata));
    step(OP_ANDIM, 12'h030, 8'h3, 12'h893, 4'h6, 2'b10);
    step(OP_LDA, 12'h00f, 8'h0, 12'h894, 4'h6, 2'b10);
    step(OP_LDA, 12'h030, 8'h0, 12'h895, 4'h2, 2'b10);
    step(OP_EORIM, 12'h030, 8'h7, 12'h896, 4'h2, 2'b10);
    step(OP_ORIM, 12'h030, 8'h8, 12'h897, 4'h2, 2'b10);
    step(OP_LDA, 12'h030, 8'h0, 12'h898, 4'hd, 2'b10);
    step(OP_ADI, 12'h0, 8'h5, 12'h899, 4'h2, 2'b01);
    step(OP_TABLE_JUMP_OP, 12'h0, 8'h0, 12'h8a2, 4'h2, 2'b01);
    // Five nested calls overflow the four-entry stack
    step(OP_CALL, 12'h110, 8'h0, 12'h910, 4'h2, 2'b01);
    step(OP_ADI, 12'h0, 8'h0, 12'h911, 4'h2, 2'b00);
    step(OP_CALL, 12'h120, 8'h0, 12'h920, 4'h2, 2'b00);
    step(OP_CALL, 12'h130, 8'h0, 12'h930, 4'h2, 2'b00);
    step(OP_CALL, 12'h140, 8'h0, 12'h940, 4'h2, 2'b00);
    step(OP_CALL, 12'h150, 8'h0, 12'h950, 4'h2, 2'b00);
    rdc(8'h80, 32'h82950, 1'b0);
    step(OP_ADI, 12'h0, 8'hf, 12'h951, 4'h1, 2'b01);
    step(OP_RETURN_WITH_CONSTANT_OP, 12'h0, 8'h5c, 12'h941, 4'hc, 2'b01);
    chk("tbr", 32'h5, 32'(table_branch_reg));
    step(OP_RETURN_FROM_INTERRUPT_OP, 12'h0, 8'h0, 12'h931, 4'hc, 2'b00);
    step(OP_RETURN_FROM_INTERRUPT_OP, 12'h0, 8'h0, 12'h921, 4'hc, 2'b00);
    step(OP_RETURN_FROM_INTERRUPT_OP, 12'h0, 8'h0, 12'h912, 4'hc, 2'b00);
    step(OP_RETURN_FROM_INTERRUPT_OP, 12'h0, 8'h0, 12'h000, 4'hc, 2'b00);
    rdc(8'h80, 32'hc000, 1'b0);
    // Interrupts share the stack; timer wins over port
    step(OP_JMP, 12'h123, 8'h0, 12'h123, 4'hc, 2'b00);
    irq(1'b1, 1'b1, 12'h002);
    irq(1'b0, 1'b1, 12'h004);
    rdc(8'h80, 32'h4c004, 1'b0);
    step(OP_RETURN_FROM_INTERRUPT_OP, 12'h0, 8'h0, 12'h002, 4'hc, 2'b00);
    step(OP_RETURN_FROM_INTERRUPT_OP, 12'h0, 8'h0, 12'h123, 4'hc, 2'b00);
    // Low power, stopped run and frozen clock enable all hold state
    @(posedge pclk);
    low_power_mode <= 1'b1;
    step(OP_ADI, 12'h0, 8'h1, 12'h123, 4'hc, 2'b00);
    @(posedge pclk);
    low_power_mode <= 1'b0;
    chk("mem", 32'h6, 32'(i_mem.mem[10'h3a5]));
    apb(1'b1, 8'h84, 32'h0);
    step(OP_ADI, 12'h0, 8'h1, 12'h123, 4'hc, 2'b00);
    apb(1'b1, 8'h84, 32'h1);
    @(posedge pclk);
    clk_en <= 1'b0;
    step(OP_ADI, 12'h0, 8'h1, 12'h123, 4'hc, 2'b00);
    @(posedge pclk);
    clk_en <= 1'b1;
    step(OP_ADI, 12'h0, 8'h1, 12'h124, 4'hd, 2'b00);
    step(OP_STA, 12'h00e, 8'h0, 12'h125, 4'hd, 2'b00);
    chk("tbr", 32'hd, 32'(table_branch_reg));
    step(OP_LDA, 12'h010, 8'h0, 12'h126, 4'h5, 2'b00);
    wrap_up();
  end
endmodule

// >>> hw/fbc_core.sv
// Four-bit core datapath: program counter, ALU with carry, accumulator,
// table branch register, data pointer and the shared return stack.
// Assumes an external sequencer offers one decoded instruction per cycle,
// program and data memory outside, and APB access on the same clock.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps

// Operation
// RQ1 - Twelve-bit counter: page bit plus eleven-bit count
// RQ2 - Jump can set the page bit
// RQ3 - Counter loaded each instruction, 4K reach
// RQ4 - ALU arithmetic, decimal, logic, branch, shift
// RQ5 - Carry captures arithmetic overflow or borrow
// RQ6 - Carry pushed; interrupt return restores, constant return not
// RQ7 - Four-bit accumulator, transfers with registers and memory
// RQ8 - Table jump target: page nibble, table, accumulator
// RQ9 - Constant return loads table and accumulator
// RQ10 - Pointer of three, three and four bits
// RQ11 - Index location uses the pointer address
// RQ12 - Four thirteen-bit entries, carry on top bit
// RQ13 - Last-in first-out, popped by both returns
// RQ14 - Calls and interrupts share one stack
// RQ15 - Fifth push drops the oldest entry
// RQ16 - State held during low-power modes
// RQ17 - Reset, timer and port vectors
// RQ18 - Table, index and pointer as system registers
// RQ19 - Decimal adjust follows conventional BCD correction
module fbc_core import fbc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [4:0] instr_op,
  input wire logic [11:0] instr_addr,
  input wire logic [7:0] instr_imm,
  input wire logic [3:0] mem_rdata,
  input wire logic irq_timer,
  input wire logic irq_port,
  input wire logic low_power_mode,
  output logic [11:0] fetch_addr,
  output logic [3:0] accum_reg,
  output logic carry_flag,
  output logic [3:0] table_branch_reg,
  output logic [2:0] pointer_high_part,
  output logic [2:0] pointer_middle_part,
  output logic [3:0] pointer_low_part,
  output logic mem_we,
  output logic [9:0] mem_addr,
  output logic [3:0] mem_wdata,
  output logic irq_ack
);

  // ****************************************
  // Issue decode
  // ****************************************
  fbc_op_t op;
  logic run_en;
  logic push;
  logic pop;
  logic [STACK_W-1:0] push_data;
  logic [STACK_W-1:0] stack_top;
  logic [2:0] stack_depth;
  logic [3:0] next_acc;
  logic next_cy;
  logic [11:0] next_pc;
  logic [3:0] next_tbr_exec;
  logic wr_en;
  logic [3:0] wr_val;

  // Low-power mode blocks issue, so every register not written over APB holds
  assign op = fbc_op_t'(instr_op);
  wire logic active = run_en && !low_power_mode; // RQ16
  wire logic step = active && instr_valid;
  wire logic irq_any = irq_timer || irq_port;
  wire logic irq_take = active && !instr_valid && irq_any;

  // Address decode of the instruction's memory operand
  wire logic hit_tbr = instr_addr == {6'h00, IDX_TBR};
  wire logic hit_inx = instr_addr == {6'h00, IDX_INX};
  wire logic hit_dpl = instr_addr == {6'h00, IDX_DPL};
  wire logic hit_dpm = instr_addr == {6'h00, IDX_DPM};
  wire logic hit_dph = instr_addr == {6'h00, IDX_DPH};
  wire logic hit_sys = hit_tbr || hit_dpl || hit_dpm || hit_dph; // RQ18
  wire logic [9:0] pointer_addr =
    {pointer_high_part, pointer_middle_part, pointer_low_part}; // RQ10

  // System registers are read here; everything else comes from memory
  wire logic [3:0] sys_val =
    hit_tbr ? table_branch_reg :
    hit_dpl ? pointer_low_part :
    hit_dpm ? {1'b0, pointer_middle_part} :
    {1'b0, pointer_high_part};
  wire logic [3:0] src = hit_sys ? sys_val : mem_rdata; // RQ7

  // Sequential address: page bit kept, only the low eleven bits count
  wire logic [11:0] pc_inc = {fetch_addr[11], fetch_addr[10:0] + 11'h001}; // RQ1
  wire logic [11:0] br_target = {fetch_addr[11], instr_addr[10:0]};
  wire logic [11:0] table_jump_op_target =
    {fetch_addr[11:8], table_branch_reg, accum_reg}; // RQ8

  // Five-bit operands keep the carry out of each nibble sum
  wire logic [4:0] a5 = {1'b0, accum_reg};
  wire logic [4:0] s5 = {1'b0, src};
  wire logic [4:0] i5 = {1'b0, instr_imm[3:0]};
  wire logic [4:0] c5 = {4'h0, carry_flag};
  wire logic [4:0] b5 = {4'h0, ~carry_flag};

  // ****************************************
  // ALU and next-state selection
  // ****************************************
  // Subtraction leaves carry set when no borrow occurred
  always_comb begin
    logic [4:0] r5;
    r5 = 5'h00;
    next_acc = accum_reg;
    next_cy = carry_flag;
    next_pc = pc_inc; // RQ3
    next_tbr_exec = table_branch_reg;
    push = 1'b0;
    pop = 1'b0;
    push_data = {carry_flag, pc_inc};
    wr_en = 1'b0;
    wr_val = accum_reg;
    case (op)
      OP_ADD, OP_ADC, OP_ADI: begin
        r5 = (op == OP_ADI) ? a5 + i5 : a5 + s5 + ((op == OP_ADC) ? c5 : 5'h00);
        next_acc = r5[3:0]; // RQ4
        next_cy = r5[4]; // RQ5
      end
      OP_SUB, OP_SBC, OP_SBI: begin
        r5 = (op == OP_SBI) ? a5 - i5 : a5 - s5 - ((op == OP_SBC) ? b5 : 5'h00);
        next_acc = r5[3:0]; // RQ4
        next_cy = ~r5[4]; // RQ5
      end
      OP_DAA: begin
        if (accum_reg > BCD_MAX || carry_flag) begin
          next_acc = accum_reg + BCD_ADD_FIX; // RQ19
          next_cy = 1'b1;
        end
      end
      OP_DAS: begin
        if (!carry_flag) begin
          next_acc = accum_reg + BCD_SUB_FIX; // RQ19
        end
      end
      OP_AND: next_acc = accum_reg & src;
      OP_EOR: next_acc = accum_reg ^ src;
      OP_OR: next_acc = accum_reg | src;
      OP_ANDIM, OP_EORIM, OP_ORIM: begin
        wr_en = 1'b1;
        wr_val = (op == OP_ANDIM) ? src & instr_imm[3:0] :
                 (op == OP_EORIM) ? src ^ instr_imm[3:0] : src | instr_imm[3:0]; // RQ4
      end
      OP_BA: begin
        if (accum_reg[instr_imm[1:0]]) begin
          next_pc = br_target;
        end
      end
      OP_BAZ: begin
        if (accum_reg == 4'h0) begin
          next_pc = br_target;
        end
      end
      OP_BNZ: begin
        if (accum_reg != 4'h0) begin
          next_pc = br_target;
        end
      end
      OP_BC: begin
        if (carry_flag) begin
          next_pc = br_target;
        end
      end
      OP_BNC: begin
        if (!carry_flag) begin
          next_pc = br_target;
        end
      end
      OP_SHR: begin
        next_acc = {1'b0, accum_reg[3:1]}; // RQ4
        next_cy = accum_reg[0];
      end
      OP_LDA: next_acc = src; // RQ7
      OP_STA: wr_en = 1'b1;
      OP_JMP: next_pc = instr_addr; // RQ2
      OP_CALL: begin
        push = 1'b1; // RQ14
        next_pc = br_target;
      end
      OP_RETURN_FROM_INTERRUPT_OP: begin
        pop = 1'b1;
        next_pc = stack_top[11:0]; // RQ13
        next_cy = stack_top[12]; // RQ6
      end
      OP_RETURN_WITH_CONSTANT_OP: begin
        pop = 1'b1;
        next_pc = stack_top[11:0]; // RQ13
        next_tbr_exec = instr_imm[7:4]; // RQ9
        next_acc = instr_imm[3:0];
      end
      OP_TABLE_JUMP_OP: next_pc = table_jump_op_target; // RQ8
      default: next_pc = pc_inc;
    endcase
    if (wr_en && hit_tbr) begin
      next_tbr_exec = wr_val;
    end
  end

  // Interrupt entry saves the address of the instruction not yet run
  wire logic do_push = (step && push) || irq_take; // RQ14
  wire logic do_pop = step && pop;
  wire logic [STACK_W-1:0] stack_in =
    irq_take ? {carry_flag, fetch_addr} : push_data; // RQ6
  wire logic [11:0] irq_vector = irq_timer ? TIMER_VECTOR : PORT_VECTOR; // RQ17

  fbc_stack u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .push(do_push),
    .pop(do_pop),
    .push_data(stack_in),
    .top(stack_top),
    .depth(stack_depth)
  );

  // ****************************************
  // APB slave decode
  // ****************************************
  wire logic [5:0] apb_idx = paddr[7:2];
  wire logic apb_map = (paddr[1:0] == 2'b00) &&
    (apb_idx == IDX_TBR || apb_idx == IDX_INX || apb_idx == IDX_DPL ||
     apb_idx == IDX_DPM || apb_idx == IDX_DPH || apb_idx == IDX_STATUS ||
     apb_idx == IDX_CTRL);
  wire logic apb_wr = psel && penable && pready && pwrite && apb_map;
  wire logic [31:0] status_word = {12'h000, stack_depth, carry_flag, accum_reg, fetch_addr};
  // Index location has no backing here, so software reads it as zero
  wire logic [31:0] apb_rd =
    (apb_idx == IDX_TBR) ? {28'h0, table_branch_reg} :
    (apb_idx == IDX_DPL) ? {28'h0, pointer_low_part} :
    (apb_idx == IDX_DPM) ? {29'h0, pointer_middle_part} :
    (apb_idx == IDX_DPH) ? {29'h0, pointer_high_part} :
    (apb_idx == IDX_STATUS) ? status_word :
    (apb_idx == IDX_CTRL) ? {31'h0, run_en} : 32'h0;

  // Software writes win over an instruction writing the same register
  wire logic sw_tbr = apb_wr && apb_idx == IDX_TBR;
  wire logic sw_dpl = apb_wr && apb_idx == IDX_DPL;
  wire logic sw_dpm = apb_wr && apb_idx == IDX_DPM;
  wire logic sw_dph = apb_wr && apb_idx == IDX_DPH;
  wire logic ex_wr = step && wr_en;

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (clk_en) begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !apb_map;
      prdata <= (psel && penable && !pready && !pwrite && apb_map) ? apb_rd : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_en <= CTRL_RUN_RST;
    end else if (clk_en && apb_wr && apb_idx == IDX_CTRL) begin
      run_en <= pwdata[0];
    end
  end

  // ****************************************
  // Program counter, accumulator and carry
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_addr <= RESET_VECTOR; // RQ17
      accum_reg <= 4'h0;
      carry_flag <= 1'b0;
      irq_ack <= 1'b0;
    end else if (clk_en) begin
      irq_ack <= irq_take;
      if (step) begin
        fetch_addr <= next_pc; // RQ3
        accum_reg <= next_acc;
        carry_flag <= next_cy;
      end else if (irq_take) begin
        fetch_addr <= irq_vector; // RQ17
      end
    end
  end

  // ****************************************
  // Table branch register and data pointer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_branch_reg <= TBR_RST;
    end else if (clk_en && sw_tbr) begin
      table_branch_reg <= pwdata[3:0];
    end else if (clk_en && step) begin
      table_branch_reg <= next_tbr_exec; // RQ9
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pointer_low_part <= DPL_RST;
      pointer_middle_part <= DPM_RST;
      pointer_high_part <= DPH_RST;
    end else if (clk_en) begin
      if (sw_dpl || (ex_wr && hit_dpl)) begin
        pointer_low_part <= sw_dpl ? pwdata[3:0] : wr_val; // RQ18
      end
      if (sw_dpm || (ex_wr && hit_dpm)) begin
        pointer_middle_part <= sw_dpm ? pwdata[2:0] : wr_val[2:0];
      end
      if (sw_dph || (ex_wr && hit_dph)) begin
        pointer_high_part <= sw_dph ? pwdata[2:0] : wr_val[2:0];
      end
    end
  end

  // Memory write strobe follows the instruction by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_we <= 1'b0;
      mem_addr <= 10'h000;
      mem_wdata <= 4'h0;
    end else if (clk_en) begin
      mem_we <= ex_wr && !hit_sys;
      if (ex_wr && !hit_sys) begin
        mem_addr <= hit_inx ? pointer_addr : instr_addr[9:0]; // RQ11
        mem_wdata <= wr_val;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk iff clk_en); endclocking
  default disable iff (!presetn);

  sequence s_call;
    step && op == OP_CALL && !sw_tbr;
  endsequence

  sequence s_irq;
    irq_take;
  endsequence

  chk_pc_count: assert property (step && op == OP_NOP |=> // RQ1
    fetch_addr == {$past(fetch_addr[11]), $past(fetch_addr[10:0]) + 11'h001})
    else $error("sequential fetch address wrong");
  chk_jump_page: assert property (step && op == OP_JMP |=> // RQ2
    fetch_addr == $past(instr_addr))
    else $error("jump did not load full address");
  chk_add_carry: assert property (step && op == OP_ADD |=> // RQ5
    {carry_flag, accum_reg} == $past(a5) + $past(s5))
    else $error("add result or carry wrong");
  chk_table_jump: assert property (step && op == OP_TABLE_JUMP_OP |=> // RQ8
    fetch_addr == $past(table_jump_op_target))
    else $error("table jump target wrong");
  chk_const_return: assert property (step && op == OP_RETURN_WITH_CONSTANT_OP && !sw_tbr |=> // RQ9
    table_branch_reg == $past(instr_imm[7:4]) && accum_reg == $past(instr_imm[3:0])
    && carry_flag == $past(carry_flag))
    else $error("constant return load wrong");
  chk_call_saved: assert property (s_call |=> // RQ12
    stack_top == {$past(carry_flag), $past(pc_inc)})
    else $error("call did not save carry and return address");
  chk_irq_vector: assert property (s_irq |=> // RQ17
    irq_ack && (fetch_addr == TIMER_VECTOR || fetch_addr == PORT_VECTOR)
    && stack_top[11:0] == $past(fetch_addr))
    else $error("interrupt entry wrong");
  chk_return_from_interrupt_op_carry: assert property (step && op == OP_RETURN_FROM_INTERRUPT_OP |=> // RQ6
    carry_flag == $past(stack_top[12]) && fetch_addr == $past(stack_top[11:0]))
    else $error("interrupt return did not restore");
  chk_depth_full: assert property (stack_depth == 3'h4 && do_push && !do_pop |=> // RQ15
    stack_depth == 3'h4)
    else $error("stack depth passed four");
  chk_sleep_hold: assert property (low_power_mode && !sw_tbr |=> // RQ16
    $stable(fetch_addr) && $stable(accum_reg) && $stable(table_branch_reg))
    else $error("state changed in low power");
  chk_index_addr: assert property (step && op == OP_STA && hit_inx |=> // RQ11
    mem_we && mem_addr == $past(pointer_addr))
    else $error("index write used wrong address");

endmodule

// >>> hw/fbc_pkg.sv
// Constants, opcodes and register indices of the four-bit core datapath.
// Assumes one 200 MHz clock domain and an APB register port.
package fbc_pkg;

  // ****************************************
  // Widths and fixed addresses
  // ****************************************
  localparam int PC_W = 12;
  localparam int STACK_W = 13;
  localparam int STACK_DEPTH = 4;
  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam logic [11:0] TIMER_VECTOR = 12'h002;
  localparam logic [11:0] PORT_VECTOR = 12'h004;

  // ****************************************
  // System register indices (byte address is four times the index)
  // ****************************************
  localparam logic [5:0] IDX_TBR = 6'h0e;
  localparam logic [5:0] IDX_INX = 6'h0f;
  localparam logic [5:0] IDX_DPL = 6'h10;
  localparam logic [5:0] IDX_DPM = 6'h11;
  localparam logic [5:0] IDX_DPH = 6'h12;
  localparam logic [5:0] IDX_STATUS = 6'h20;
  localparam logic [5:0] IDX_CTRL = 6'h21;

  // Status word field positions
  localparam int ST_ACC_LSB = 12;
  localparam int ST_CY_BIT = 16;
  localparam int ST_DEPTH_LSB = 17;

  // ****************************************
  // Reset values and decimal-adjust constants
  // ****************************************
  localparam logic [3:0] TBR_RST = 4'h0;
  localparam logic [3:0] DPL_RST = 4'h0;
  localparam logic [2:0] DPM_RST = 3'h0;
  localparam logic [2:0] DPH_RST = 3'h0;
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_ADD_FIX = 4'h6;
  localparam logic [3:0] BCD_SUB_FIX = 4'ha;

  // Instruction codes offered on the issue port
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
    OP_SBC = 5'h04, OP_ADI = 5'h05, OP_SBI = 5'h06, OP_DAA = 5'h07,
    OP_DAS = 5'h08, OP_AND = 5'h09, OP_EOR = 5'h0a, OP_OR = 5'h0b,
    OP_ANDIM = 5'h0c, OP_EORIM = 5'h0d, OP_ORIM = 5'h0e, OP_BA = 5'h0f,
    OP_BAZ = 5'h10, OP_BNZ = 5'h11, OP_BC = 5'h12, OP_BNC = 5'h13,
    OP_SHR = 5'h14, OP_LDA = 5'h15, OP_STA = 5'h16, OP_JMP = 5'h17,
    OP_CALL = 5'h18, OP_RETURN_FROM_INTERRUPT_OP = 5'h19, OP_RETURN_WITH_CONSTANT_OP = 5'h1a, OP_TABLE_JUMP_OP = 5'h1b
  } fbc_op_t;

endpackage

// >>> hw/fbc_stack.sv
// Four-entry return stack holding carry and program counter.
// Assumes the core never pushes and pops in the same cycle.
`timescale 1ns/1ps
module fbc_stack import fbc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic push,
  input wire logic pop,
  input wire logic [STACK_W-1:0] push_data,
  output logic [STACK_W-1:0] top,
  output logic [2:0] depth
);

  logic [STACK_W-1:0] entry [STACK_DEPTH]; // RQ12

  // ****************************************
  // Shift-register entries
  // ****************************************
  // A push shifts every entry down, so a fifth push loses the bottom one
  for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_entry
    wire logic [STACK_W-1:0] from_above = (i == 0) ? push_data : entry[(i == 0) ? 0 : i-1];
    wire logic [STACK_W-1:0] from_below =
      (i == STACK_DEPTH-1) ? '0 : entry[(i == STACK_DEPTH-1) ? i : i+1];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        entry[i] <= '0;
      end else if (clk_en && push) begin
        entry[i] <= from_above; // RQ15
      end else if (clk_en && pop) begin
        entry[i] <= from_below; // RQ13
      end
    end
  end

  assign top = entry[0];

  // Depth saturates at four; overflow simply keeps the pool full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth <= 3'h0;
    end else if (clk_en && push && depth != 3'(STACK_DEPTH)) begin
      depth <= depth + 3'h1;
    end else if (clk_en && pop && depth != 3'h0) begin
      depth <= depth - 3'h1;
    end
  end

endmodule
